// ---- design/sag_addr_gen.sv ----
// Operand address generator: segment choice, effective offset, physical address.
//
// Summary of operation
// (R1) Fetches always use the code segment.
// (R2) Stack and base-pointer references use stack segment.
// (R3) String destination-index references use extra segment.
// (R4) Otherwise data references use the data segment.
// (R5) Override prefix replaces the implicit segment of data references only.
// (R6) Offset sums displacement, base and index.
// (R7) Offset carry is discarded, wraps at 16 bits.
// (R8) Short displacement is sign-extended to 16 bits.
// (R9) Base is general base or base pointer only.
// (R10) Index is source or destination index only.
// (R11) Displacement is 8 or 16 bit immediate.
// (R12) Direct mode: offset is displacement alone.
// (R13) Register indirect: offset is one pointer register.
// (R14) Based: displacement plus one base register.
// (R15) Indexed: displacement plus one index register.
// (R16) Based indexed: base plus index, no displacement.
// (R17) Based indexed with displacement: all three summed.
// (R18) Register and immediate operands make no address unless they are code fetches.
// (R19) Physical address is segment times sixteen plus offset.
// (R20) Override lasts for one instruction only.
`timescale 1ns/10ps
module sag_addr_gen #(
   parameter int OFS_W = sag_pkg::OFS_W,
   parameter int PHYS_W = sag_pkg::PHYS_W
) (
   input wire logic clk,
   input wire logic rst_n,
   // Prefix decode and instruction boundary.
   input wire logic prefix_valid,
   input wire sag_pkg::sag_seg_t prefix_seg,
   input wire logic instr_done,
   // Reference request from the decoder.
   input wire logic req_valid,
   output logic req_ready,
   input wire sag_pkg::sag_ref_t ref_kind,
   input wire sag_pkg::sag_mode_t mode,
   input wire logic base_is_ptr,
   input wire logic index_is_dst,
   input wire sag_pkg::sag_ptr_t indirect_sel,
   input wire logic disp_wide,
   input wire logic [OFS_W-1:0] disp,
   input wire logic [OFS_W-1:0] fetch_ofs,
   // Register file contents.
   input wire logic [OFS_W-1:0] code_seg_reg,
   input wire logic [OFS_W-1:0] data_segment_reg,
   input wire logic [OFS_W-1:0] stack_seg_reg,
   input wire logic [OFS_W-1:0] extra_segment_reg,
   input wire logic [OFS_W-1:0] general_base_reg,
   input wire logic [OFS_W-1:0] base_pointer_reg,
   input wire logic [OFS_W-1:0] src_index_reg,
   input wire logic [OFS_W-1:0] dest_index_reg,
   // Result towards the bus interface unit.
   output logic addr_valid,
   input wire logic addr_ready,
   output logic [PHYS_W-1:0] phys_addr,
   output logic [OFS_W-1:0] eff_offset,
   output sag_pkg::sag_seg_t seg_used,
   output logic no_mem
);

   initial begin
      if (OFS_W != sag_pkg::OFS_W || PHYS_W != OFS_W + sag_pkg::SEG_SHIFT) begin
         $error("sag_addr_gen: widths must be 16-bit offset and 20-bit address");
      end
      if (sag_pkg::SEG_W != OFS_W) begin
         $error("sag_addr_gen: segment and offset widths must match");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Override prefix held for the current instruction.

   logic ovr_pending;
   sag_pkg::sag_seg_t ovr_seg;
   logic ovr_active;
   sag_pkg::sag_seg_t ovr_choice;

   // A prefix seen in the same cycle as the previous instruction's end belongs
   // to the next instruction, so the prefix wins over the clear.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovr_pending <= 1'b0;
      end else if (prefix_valid) begin
         ovr_pending <= 1'b1;
      end else if (instr_done) begin
         ovr_pending <= 1'b0; // see (R20)
      end
   end

   // The held segment is only read while the flag is set, so it may linger.
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ovr_seg <= sag_pkg::SAG_SEG_DATA;
      end else if (prefix_valid) begin
         ovr_seg <= prefix_seg;
      end
   end

   // A prefix in the same cycle as its request applies at once.
   assign ovr_active = ovr_pending || prefix_valid;
   assign ovr_choice = prefix_valid ? prefix_seg : ovr_seg;

   ////////////////////////////////////////////////////////////////////////////
   // Address element selection per mode.

   logic use_disp;
   logic use_base;
   logic use_index;
   logic is_mem;
   logic [OFS_W-1:0] base_val;
   logic [OFS_W-1:0] index_val;
   logic [OFS_W-1:0] ptr_base;
   logic [OFS_W-1:0] ptr_index;
   logic uses_base_ptr;

   always_comb begin
      use_disp = 1'b0;
      use_base = 1'b0;
      use_index = 1'b0;
      is_mem = 1'b1;
      unique case (mode)
         sag_pkg::SAG_MODE_REG, sag_pkg::SAG_MODE_IMM: begin
            is_mem = 1'b0; // see (R18)
         end
         sag_pkg::SAG_MODE_DIRECT: begin
            use_disp = 1'b1; // see (R12)
         end
         sag_pkg::SAG_MODE_INDIRECT: begin
            use_base = indirect_sel[1]; // see (R13)
            use_index = !indirect_sel[1];
         end
         sag_pkg::SAG_MODE_BASED: begin
            use_disp = 1'b1; // see (R14)
            use_base = 1'b1;
         end
         sag_pkg::SAG_MODE_INDEXED: begin
            use_disp = 1'b1; // see (R15)
            use_index = 1'b1;
         end
         sag_pkg::SAG_MODE_BASED_IDX: begin
            use_base = 1'b1; // see (R16)
            use_index = 1'b1;
         end
         sag_pkg::SAG_MODE_BASED_IDX_DISP: begin
            use_disp = 1'b1; // see (R17)
            use_base = 1'b1;
            use_index = 1'b1;
         end
         // An illegal mode code makes no address rather than a stray one.
         default: begin
            is_mem = 1'b0;
         end
      endcase
   end

   // In indirect mode the pointer selector replaces the base and index picks.
   always_comb begin
      if (mode == sag_pkg::SAG_MODE_INDIRECT) begin
         if (indirect_sel == sag_pkg::SAG_PTR_BASE_PTR) begin
            ptr_base = base_pointer_reg;
         end else begin
            ptr_base = general_base_reg;
         end
         if (indirect_sel == sag_pkg::SAG_PTR_DST_IDX) begin
            ptr_index = dest_index_reg;
         end else begin
            ptr_index = src_index_reg;
         end
         uses_base_ptr = (indirect_sel == sag_pkg::SAG_PTR_BASE_PTR);
      end else begin
         if (base_is_ptr) begin
            ptr_base = base_pointer_reg; // see (R9)
         end else begin
            ptr_base = general_base_reg;
         end
         if (index_is_dst) begin
            ptr_index = dest_index_reg; // see (R10)
         end else begin
            ptr_index = src_index_reg;
         end
         uses_base_ptr = base_is_ptr && use_base;
      end
   end

   assign base_val = ptr_base;
   assign index_val = ptr_index;

   ////////////////////////////////////////////////////////////////////////////
   // Offset and segment.

   logic [OFS_W-1:0] mem_ofs;
   logic [OFS_W-1:0] next_offset;
   sag_pkg::sag_seg_t next_seg;
   logic [OFS_W-1:0] seg_val;
   logic [PHYS_W-1:0] next_phys;
   logic is_fetch;

   sag_offset_calc #(
      .WIDTH(OFS_W)
   ) u_ofs (
      .use_disp(use_disp),
      .disp_wide(disp_wide),
      .disp(disp),
      .use_base(use_base),
      .base_val(base_val),
      .use_index(use_index),
      .index_val(index_val),
      .offset(mem_ofs)
   );

   sag_seg_select u_seg (
      .ref_kind(ref_kind),
      .uses_base_ptr(uses_base_ptr),
      .override_valid(ovr_active),
      .override_seg(ovr_choice),
      .seg_sel(next_seg)
   );

   // Code fetches, immediates included, come from the instruction pointer
   // offset rather than from the operand adder.
   assign is_fetch = (ref_kind == sag_pkg::SAG_REF_FETCH);
   assign next_offset = is_fetch ? fetch_ofs : mem_ofs; // see (R1)

   // Every code of the two-bit selector names a register, so no default.
   always_comb begin
      unique case (next_seg)
         sag_pkg::SAG_SEG_CODE: begin
            seg_val = code_seg_reg;
         end
         sag_pkg::SAG_SEG_STACK: begin
            seg_val = stack_seg_reg;
         end
         sag_pkg::SAG_SEG_EXTRA: begin
            seg_val = extra_segment_reg;
         end
         sag_pkg::SAG_SEG_DATA: begin
            seg_val = data_segment_reg;
         end
      endcase
   end

   // The 20-bit sum also drops its own carry, wrapping at the top of memory.
   assign next_phys = PHYS_W'({seg_val, {sag_pkg::SEG_SHIFT{1'b0}}} +
                              {{sag_pkg::SEG_SHIFT{1'b0}}, next_offset}); // see (R19)

   ////////////////////////////////////////////////////////////////////////////
   // Output stage: holds a result until the bus interface takes it.

   logic take;
   logic addr_made;

   // Ready is combinational so that a drained stage refills in the same cycle.
   assign req_ready = !addr_valid || addr_ready;
   assign take = req_valid && req_ready;
   // Register and immediate operands report no address unless they are code fetches.
   assign addr_made = is_mem || is_fetch;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_valid <= 1'b0;
      end else if (take) begin
         addr_valid <= 1'b1;
      end else if (addr_ready) begin
         addr_valid <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         phys_addr <= sag_pkg::SAG_PHYS_RESET;
      end else if (take) begin
         phys_addr <= addr_made ? next_phys : sag_pkg::SAG_PHYS_RESET; // see (R18)
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         eff_offset <= sag_pkg::SAG_OFS_RESET;
      end else if (take) begin
         eff_offset <= addr_made ? next_offset : sag_pkg::SAG_OFS_RESET;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         seg_used <= sag_pkg::SAG_SEG_DATA;
      end else if (take) begin
         seg_used <= next_seg;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         no_mem <= 1'b0;
      end else if (take) begin
         no_mem <= !addr_made;
      end
   end

endmodule

// ---- design/sag_offset_calc.sv ----
// Effective offset adder: displacement, base and index summed modulo 2^16.
`timescale 1ns/10ps
module sag_offset_calc #(
   parameter int WIDTH = 16
) (
   input wire logic use_disp,
   input wire logic disp_wide,
   input wire logic [WIDTH-1:0] disp,
   input wire logic use_base,
   input wire logic [WIDTH-1:0] base_val,
   input wire logic use_index,
   input wire logic [WIDTH-1:0] index_val,
   output logic [WIDTH-1:0] offset
);

   initial begin
      if (WIDTH <= sag_pkg::DISP8_W) begin
         $error("sag_offset_calc: WIDTH must exceed the short displacement width");
      end
   end

   logic [WIDTH-1:0] disp_ext;
   logic [WIDTH-1:0] term_disp;
   logic [WIDTH-1:0] term_base;
   logic [WIDTH-1:0] term_index;

   // A short displacement is sign-extended, a wide one is used as given.
   always_comb begin
      if (disp_wide) begin
         disp_ext = disp;
      end else begin
         disp_ext = {{(WIDTH - sag_pkg::DISP8_W){disp[sag_pkg::DISP8_W-1]}},
                     disp[sag_pkg::DISP8_W-1:0]}; // see (R8)
      end
   end

   assign term_disp = use_disp ? disp_ext : '0; // see (R11)
   assign term_base = use_base ? base_val : '0;
   assign term_index = use_index ? index_val : '0;

   // The sum is held to WIDTH bits so any carry out simply falls away.
   assign offset = WIDTH'(term_disp + term_base + term_index); // see (R6) see (R7)

endmodule

// ---- design/sag_pkg.sv ----
// Package of encodings and widths shared by the address generation files.
package sag_pkg;

   localparam int OFS_W = 16;
   localparam int SEG_W = 16;
   localparam int PHYS_W = 20;
   localparam int DISP8_W = 8;
   localparam int SEG_SHIFT = 4;

   // Kind of memory reference presented by the decoder.
   typedef enum logic [3:0] {
      SAG_REF_FETCH = 4'h1,
      SAG_REF_STACK = 4'h2,
      SAG_REF_STR_DST = 4'h4,
      SAG_REF_DATA = 4'h8
   } sag_ref_t;

   // Operand addressing mode.
   typedef enum logic [7:0] {
      SAG_MODE_REG = 8'h01,
      SAG_MODE_IMM = 8'h02,
      SAG_MODE_DIRECT = 8'h04,
      SAG_MODE_INDIRECT = 8'h08,
      SAG_MODE_BASED = 8'h10,
      SAG_MODE_INDEXED = 8'h20,
      SAG_MODE_BASED_IDX = 8'h40,
      SAG_MODE_BASED_IDX_DISP = 8'h80
   } sag_mode_t;

   // Segment register selector codes.
   typedef enum logic [1:0] {
      SAG_SEG_EXTRA = 2'h0,
      SAG_SEG_CODE = 2'h1,
      SAG_SEG_STACK = 2'h2,
      SAG_SEG_DATA = 2'h3
   } sag_seg_t;

   // Pointer selector for register indirect mode.
   typedef enum logic [1:0] {
      SAG_PTR_SRC_IDX = 2'h0,
      SAG_PTR_DST_IDX = 2'h1,
      SAG_PTR_GEN_BASE = 2'h2,
      SAG_PTR_BASE_PTR = 2'h3
   } sag_ptr_t;

   localparam logic [15:0] SAG_OFS_RESET = 16'h0000;
   localparam logic [19:0] SAG_PHYS_RESET = 20'h00000;

endpackage

// ---- design/sag_seg_select.sv ----
// Segment register choice: implicit rules, then a pending override prefix.
`timescale 1ns/10ps
module sag_seg_select (
   input wire sag_pkg::sag_ref_t ref_kind,
   input wire logic uses_base_ptr,
   input wire logic override_valid,
   input wire sag_pkg::sag_seg_t override_seg,
   output sag_pkg::sag_seg_t seg_sel
);

   sag_pkg::sag_seg_t implicit_seg;

   always_comb begin
      unique case (ref_kind)
         sag_pkg::SAG_REF_FETCH: begin
            implicit_seg = sag_pkg::SAG_SEG_CODE; // see (R1)
         end
         sag_pkg::SAG_REF_STACK: begin
            implicit_seg = sag_pkg::SAG_SEG_STACK; // see (R2)
         end
         sag_pkg::SAG_REF_STR_DST: begin
            implicit_seg = sag_pkg::SAG_SEG_EXTRA; // see (R3)
         end
         sag_pkg::SAG_REF_DATA: begin
            if (uses_base_ptr) begin
               implicit_seg = sag_pkg::SAG_SEG_STACK; // see (R2)
            end else begin
               implicit_seg = sag_pkg::SAG_SEG_DATA; // see (R4)
            end
         end
         default: begin
            implicit_seg = sag_pkg::SAG_SEG_DATA;
         end
      endcase
   end

   // Code fetches, stack pushes and pops and string destinations are fixed
   // by the core and cannot be redirected, so only operands take the prefix.
   always_comb begin
      if (override_valid && ref_kind == sag_pkg::SAG_REF_DATA) begin
         seg_sel = override_seg; // see (R5)
      end else begin
         seg_sel = implicit_seg;
      end
   end

endmodule

// ---- sim/sag_addr_gen_checker.sv ----
// Concurrent checks on the ports of the operand address generator.
`timescale 1ns/10ps
module sag_addr_gen_checker #(
   parameter int OFS_W = 16,
   parameter int PHYS_W = 20
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic prefix_valid,
   input wire sag_pkg::sag_seg_t prefix_seg,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire sag_pkg::sag_ref_t ref_kind,
   input wire sag_pkg::sag_mode_t mode,
   input wire logic base_is_ptr,
   input wire logic index_is_dst,
   input wire logic disp_wide,
   input wire logic [OFS_W-1:0] disp,
   input wire logic [OFS_W-1:0] fetch_ofs,
   input wire logic [OFS_W-1:0] code_seg_reg,
   input wire logic [OFS_W-1:0] data_segment_reg,
   input wire logic [OFS_W-1:0] stack_seg_reg,
   input wire logic [OFS_W-1:0] extra_segment_reg,
   input wire logic [OFS_W-1:0] general_base_reg,
   input wire logic [OFS_W-1:0] base_pointer_reg,
   input wire logic [OFS_W-1:0] src_index_reg,
   input wire logic [OFS_W-1:0] dest_index_reg,
   input wire logic addr_valid,
   input wire logic addr_ready,
   input wire logic [PHYS_W-1:0] phys_addr,
   input wire logic [OFS_W-1:0] eff_offset,
   input wire sag_pkg::sag_seg_t seg_used,
   input wire logic no_mem
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic take;
   logic [OFS_W-1:0] seg_val;
   logic [OFS_W-1:0] dval;
   logic [OFS_W-1:0] bi;
   assign take = req_valid && req_ready;
   assign seg_val = seg_used == sag_pkg::SAG_SEG_CODE ? code_seg_reg :
      seg_used == sag_pkg::SAG_SEG_DATA ? data_segment_reg :
      seg_used == sag_pkg::SAG_SEG_STACK ? stack_seg_reg : extra_segment_reg;
   assign dval = disp_wide ? disp : {{(OFS_W-8){disp[7]}}, disp[7:0]};
   // Truncation to the offset width is the expected wrap of the sum.
   assign bi = (base_is_ptr ? base_pointer_reg : general_base_reg) +
      (index_is_dst ? dest_index_reg : src_index_reg);
   ////////////////////////////////////////////////////////////////////////////////
   property p_fetch;
      take && ref_kind == sag_pkg::SAG_REF_FETCH |=>
         seg_used == sag_pkg::SAG_SEG_CODE && eff_offset == $past(fetch_ofs);
   endproperty
   a_fetch: assert property (p_fetch) else $error("fetch left the code segment");
   property p_stack;
      take && ref_kind == sag_pkg::SAG_REF_STACK |=> seg_used == sag_pkg::SAG_SEG_STACK;
   endproperty
   a_stack: assert property (p_stack) else $error("stack ref off stack segment");
   property p_strdst;
      take && ref_kind == sag_pkg::SAG_REF_STR_DST |=> seg_used == sag_pkg::SAG_SEG_EXTRA;
   endproperty
   a_strdst: assert property (p_strdst) else $error("string dest off extra segment");
   property p_prefix;
      take && prefix_valid && ref_kind == sag_pkg::SAG_REF_DATA &&
         mode == sag_pkg::SAG_MODE_DIRECT |=> seg_used == $past(prefix_seg);
   endproperty
   a_prefix: assert property (p_prefix) else $error("override ignored");
   property p_direct;
      take && ref_kind == sag_pkg::SAG_REF_DATA && mode == sag_pkg::SAG_MODE_DIRECT
         |=> eff_offset == $past(dval);
   endproperty
   a_direct: assert property (p_direct) else $error("direct offset wrong");
   property p_bidx;
      take && ref_kind == sag_pkg::SAG_REF_DATA && mode == sag_pkg::SAG_MODE_BASED_IDX
         |=> eff_offset == $past(bi);
   endproperty
   a_bidx: assert property (p_bidx) else $error("based indexed offset wrong");
   property p_bidxd;
      take && ref_kind == sag_pkg::SAG_REF_DATA && mode == sag_pkg::SAG_MODE_BASED_IDX_DISP
         |=> eff_offset == $past(bi) + $past(dval);
   endproperty
   a_bidxd: assert property (p_bidxd) else $error("three-part offset wrong");
   property p_nomem;
      take && ref_kind != sag_pkg::SAG_REF_FETCH && mode inside {sag_pkg::SAG_MODE_REG,
         sag_pkg::SAG_MODE_IMM} |=> no_mem && phys_addr == '0 && eff_offset == '0;
   endproperty
   a_nomem: assert property (p_nomem) else $error("operand mode made an address");
   property p_phys;
      addr_valid && !no_mem |-> phys_addr == (PHYS_W'(seg_val) << 4) + PHYS_W'(eff_offset);
   endproperty
   a_phys: assert property (p_phys) else $error("physical address wrong");
   property p_held;
      addr_valid && !addr_ready |-> !req_ready ##1 addr_valid && $stable(phys_addr);
   endproperty
   a_held: assert property (p_held) else $error("result lost while stalled");
endmodule

// ---- sim/sag_biu_model.sv ----
// Bus interface unit stand-in that takes addresses at a pace set by the bench.
`timescale 1ns/10ps
module sag_biu_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hold,
   input wire logic addr_valid,
   output logic addr_ready
);
   // Ready moves on the falling edge so that it is settled when the design samples it.
   always_ff @(negedge clk or negedge rst_n) begin
      if (!rst_n) begin
         addr_ready <= 1'b0;
      end else begin
         addr_ready <= !hold && addr_valid;
      end
   end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the operand address generator.
`timescale 1ns/10ps
module tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic prefix_valid = 1'b0;
   sag_pkg::sag_seg_t prefix_seg = sag_pkg::SAG_SEG_DATA;
   logic instr_done = 1'b0;
   logic req_valid = 1'b0;
   logic req_ready;
   sag_pkg::sag_ref_t ref_kind = sag_pkg::SAG_REF_DATA;
   sag_pkg::sag_mode_t mode = sag_pkg::SAG_MODE_DIRECT;
   logic base_is_ptr = 1'b0;
   logic index_is_dst = 1'b0;
   sag_pkg::sag_ptr_t indirect_sel = sag_pkg::SAG_PTR_SRC_IDX;
   logic disp_wide = 1'b0;
   logic [15:0] disp = 16'h0000;
   logic [15:0] fetch_ofs = 16'h0022;
   logic [15:0] code_seg_reg = 16'h12a4;
   logic [15:0] data_segment_reg = 16'h2000;
   logic [15:0] stack_seg_reg = 16'h3000;
   logic [15:0] extra_segment_reg = 16'h4000;
   logic [15:0] general_base_reg = 16'hfff0;
   logic [15:0] base_pointer_reg = 16'h0100;
   logic [15:0] src_index_reg = 16'h0020;
   logic [15:0] dest_index_reg = 16'h8000;
   logic addr_valid;
   logic addr_ready;
   logic [19:0] phys_addr;
   logic [15:0] eff_offset;
   sag_pkg::sag_seg_t seg_used;
   logic no_mem;
   logic hold = 1'b0;
   logic [15:0] ind_ofs [4] = '{16'h0020, 16'h8000, 16'hfff0, 16'h0100};
   int fail_count = 0;
   int total_checks = 0;
   always #50 clk = ~clk;
   sag_addr_gen dut_u (.*);
   sag_biu_model biu_u (.*);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [19:0] got, input logic [19:0] exp);
      total_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Selector nibble: base pointer, destination index, then the indirect pointer code.
   task automatic put(input sag_pkg::sag_ref_t k, input sag_pkg::sag_mode_t m,
      input logic [15:0] d, input logic w, input logic [3:0] sel);
      ref_kind = k;
      mode = m;
      disp = d;
      disp_wide = w;
      {base_is_ptr, index_is_dst} = sel[3:2];
      indirect_sel = sag_pkg::sag_ptr_t'(sel[1:0]);
   endtask
   // Request from the next falling edge; the take is the rising edge that sees ready.
   task automatic go();
      @(negedge clk);
      req_valid = 1'b1;
      @(posedge clk);
      for (int i = 0; i < 20 && req_ready !== 1'b1; i++) @(posedge clk);
      @(negedge clk);
      req_valid = 1'b0;
      chk(addr_valid, 1'b1);
   endtask
   task automatic ex(input sag_pkg::sag_seg_t s, input logic [15:0] o);
      logic [15:0] sv;
      sv = s == sag_pkg::SAG_SEG_CODE ? code_seg_reg : s == sag_pkg::SAG_SEG_DATA ?
         data_segment_reg : s == sag_pkg::SAG_SEG_STACK ? stack_seg_reg : extra_segment_reg;
      chk(seg_used, s);
      chk(eff_offset, o);
      chk(phys_addr, {sv, 4'h0} + {4'h0, o});
      chk(no_mem, 1'b0);
   endtask
   task automatic run(input sag_pkg::sag_ref_t k, input sag_pkg::sag_mode_t m,
      input logic [15:0] d, input logic w, input logic [3:0] sel,
      input sag_pkg::sag_seg_t s, input logic [15:0] o);
      put(k, m, d, w, sel);
      go();
      ex(s, o);
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic t_segs();
      run(sag_pkg::SAG_REF_FETCH, sag_pkg::SAG_MODE_DIRECT, 16'h0500, 1'b1, 4'h0,
         sag_pkg::SAG_SEG_CODE, 16'h0022);
      put(sag_pkg::SAG_REF_STACK, sag_pkg::SAG_MODE_DIRECT, 16'h0000, 1'b1, 4'h0);
      go();
      chk(seg_used, sag_pkg::SAG_SEG_STACK);
      run(sag_pkg::SAG_REF_STR_DST, sag_pkg::SAG_MODE_INDIRECT, 16'h0000, 1'b0, 4'h1,
         sag_pkg::SAG_SEG_EXTRA, 16'h8000);
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_DIRECT, 16'h1234, 1'b1, 4'h0,
         sag_pkg::SAG_SEG_DATA, 16'h1234);
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_BASED, 16'h00fe, 1'b0, 4'h8,
         sag_pkg::SAG_SEG_STACK, 16'h00fe);
   endtask
   task automatic t_modes();
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_DIRECT, 16'h5580, 1'b0, 4'h0,
         sag_pkg::SAG_SEG_DATA, 16'hff80);
      for (int i = 0; i < 4; i++) begin
         run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_INDIRECT, 16'h0000, 1'b0, 4'(i),
            i == 3 ? sag_pkg::SAG_SEG_STACK : sag_pkg::SAG_SEG_DATA, ind_ofs[i]);
      end
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_BASED, 16'h0020, 1'b1, 4'h0,
         sag_pkg::SAG_SEG_DATA, 16'h0010);
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_INDEXED, 16'h007f, 1'b0, 4'h0,
         sag_pkg::SAG_SEG_DATA, 16'h009f);
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_INDEXED, 16'h1000, 1'b1, 4'h4,
         sag_pkg::SAG_SEG_DATA, 16'h9000);
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_BASED_IDX, 16'h1111, 1'b1, 4'h4,
         sag_pkg::SAG_SEG_DATA, 16'h7ff0);
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_BASED_IDX_DISP, 16'h0010, 1'b0, 4'h0,
         sag_pkg::SAG_SEG_DATA, 16'h0020);
      for (int i = 0; i < 2; i++) begin
         put(sag_pkg::SAG_REF_DATA, i ? sag_pkg::SAG_MODE_IMM : sag_pkg::SAG_MODE_REG,
            16'h1234, 1'b1, 4'h0);
         go();
         chk(no_mem, 1'b1);
         chk(phys_addr, 20'h00000);
      end
   endtask
   task automatic t_prefix();
      prefix_seg = sag_pkg::SAG_SEG_EXTRA;
      prefix_valid = 1'b1;
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_DIRECT, 16'h0010, 1'b1, 4'h0,
         sag_pkg::SAG_SEG_EXTRA, 16'h0010);
      prefix_valid = 1'b0;
      run(sag_pkg::SAG_REF_FETCH, sag_pkg::SAG_MODE_DIRECT, 16'h0000, 1'b1, 4'h0,
         sag_pkg::SAG_SEG_CODE, 16'h0022);
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_DIRECT, 16'h0030, 1'b1, 4'h0,
         sag_pkg::SAG_SEG_EXTRA, 16'h0030);
      instr_done = 1'b1;
      @(negedge clk);
      instr_done = 1'b0;
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_DIRECT, 16'h0030, 1'b1, 4'h0,
         sag_pkg::SAG_SEG_DATA, 16'h0030);
   endtask
   // A stalled bus unit must hold the result and keep the next request waiting.
   task automatic t_stall();
      hold <= 1'b1;
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_DIRECT, 16'h0100, 1'b1, 4'h0,
         sag_pkg::SAG_SEG_DATA, 16'h0100);
      put(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_DIRECT, 16'h0200, 1'b1, 4'h0);
      @(negedge clk);
      req_valid = 1'b1;
      repeat (3) begin
         @(negedge clk);
         chk(req_ready, 1'b0);
         chk(eff_offset, 16'h0100);
      end
      hold <= 1'b0;
      go();
      ex(sag_pkg::SAG_SEG_DATA, 16'h0200);
   endtask
   // A reset in mid-run empties the output stage and drops a pending override.
   task automatic t_reset();
      prefix_seg = sag_pkg::SAG_SEG_STACK;
      prefix_valid = 1'b1;
      @(negedge clk);
      prefix_valid = 1'b0;
      rst_n = 1'b0;
      @(negedge clk);
      chk(addr_valid, 1'b0);
      chk(req_ready, 1'b1);
      chk(phys_addr, 20'h00000);
      chk(eff_offset, 16'h0000);
      chk(seg_used, sag_pkg::SAG_SEG_DATA);
      chk(no_mem, 1'b0);
      rst_n = 1'b1;
      run(sag_pkg::SAG_REF_DATA, sag_pkg::SAG_MODE_DIRECT, 16'h0040, 1'b1, 4'h0,
         sag_pkg::SAG_SEG_DATA, 16'h0040);
   endtask
   task automatic results();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      t_segs();
      t_modes();
      t_prefix();
      t_stall();
      t_reset();
      results();
   end
   initial begin
      #300000;
      fail_count++;
      results();
   end
endmodule
bind sag_addr_gen sag_addr_gen_checker #(.OFS_W(OFS_W), .PHYS_W(PHYS_W)) chk_u (.*);
